// >>> rtl/cpu_state_pkg.sv
// Constants, types and decode helpers for the CPU programmer-visible state.
// Assumes one core clock and an active-high asynchronous reset around it.
// Functional notes
// - Half carry is set on a carry from bit 3 into bit 4 or a borrow from bit 4 into 3.
// - The interrupt-enable flag reads 1 when interrupts are allowed and resets to 0.
// - An interrupt is taken only when its level is lower than the mask level field.
// - Mask codes 00 and 01 mean level 1, 10 level 2, 11 level 3 which blocks all.
// - The negative flag copies the top bit of each result.
// - The zero flag is set for a zero result and cleared otherwise.
// - The overflow flag shows two's complement signed overflow.
// - The carry flag shows a carry out of or borrow into bit 7, or bit 15 in word work.
// - A shift puts the bit shifted out into the carry flag.
// - The accumulator is 16 bits and byte operations use only its low byte.
// - The temporary accumulator is the 16-bit second operand, low byte for byte work.
// - PC, index, extra pointer and stack pointer are 16 bits; PC tracks the fetch.
// - The status word is the bank pointer on top and the condition codes below.
// - General registers are eight bytes per bank, up to 16 banks, chosen by the pointer.
// - The I/O area sits at the bottom of the 64 KB space with data right above it.
// - Program memory is at the top and its last locations hold the vector tables.
package cpu_state_pkg;
  localparam logic [7:0]  OFS_PC        = 8'h00;
  localparam logic [7:0]  OFS_ACC       = 8'h01;
  localparam logic [7:0]  OFS_TMP       = 8'h02;
  localparam logic [7:0]  OFS_IDX       = 8'h03;
  localparam logic [7:0]  OFS_EXT       = 8'h04;
  localparam logic [7:0]  OFS_STK       = 8'h05;
  localparam logic [7:0]  OFS_PSW       = 8'h06;
  localparam logic [7:0]  OFS_CMD       = 8'h07;
  localparam logic [7:0]  OFS_GPR_SEL   = 8'h08;
  localparam logic [7:0]  OFS_GPR_ADDR  = 8'h09;
  localparam logic [7:0]  OFS_PROBE     = 8'h0A;
  localparam logic [7:0]  OFS_IRQ_STAT  = 8'h0B;
  localparam int          COND_H        = 7;
  localparam int          COND_I        = 6;
  localparam int          COND_MASK_HI  = 5;
  localparam int          COND_MASK_LO  = 4;
  localparam int          COND_N        = 3;
  localparam int          COND_Z        = 2;
  localparam int          COND_V        = 1;
  localparam int          COND_C        = 0;
  localparam int          CMD_WORD_BIT  = 4;
  localparam logic [15:0] PC_RST        = 16'h0000;
  localparam logic [15:0] WORD_RST      = 16'h0000;
  localparam logic [7:0]  BANK_PTR_RST  = 8'h00;
  localparam logic [7:0]  COND_RST      = 8'h30;
  localparam logic [15:0] IO_LAST       = 16'h007F;
  localparam logic [15:0] PROG_FIRST    = 16'h8000;
  localparam logic [15:0] VECT_FIRST    = 16'hFFC0;
  localparam logic [15:0] BANK_BASE     = 16'h0100;
  localparam logic [3:0]  BANK_LAST     = 4'hF;
  localparam logic [1:0]  LVL_BLOCK_ALL = 2'h3;

  typedef enum logic [3:0] {
    OP_ADD, OP_ADDC, OP_SUB, OP_SUBC, OP_CMP, OP_INC, OP_DEC,
    OP_AND, OP_OR, OP_XOR, OP_SHL, OP_SHR
  } alu_op_t;

  typedef enum logic [1:0] {REGION_IO, REGION_DATA, REGION_PROG, REGION_VECT} region_t;

  function automatic logic [1:0] level_decode(input logic [1:0] code);
    level_decode = (code == 2'h0) ? 2'h1 : code;
  endfunction : level_decode
endpackage : cpu_state_pkg

// >>> rtl/alu_if.sv
// Operand and flag bundle between the core state and its flag unit.
// Assumes the unit is purely combinational.
`timescale 1ns/1ps
interface alu_if;
  import cpu_state_pkg::*;
  logic [15:0] a;
  logic [15:0] t;
  alu_op_t     op;
  logic        word;
  logic        cin;
  logic [15:0] res;
  logic        h;
  logic        n;
  logic        z;
  logic        v;
  logic        c;
  modport core (output a, t, op, word, cin, input res, h, n, z, v, c);
  modport unit (input a, t, op, word, cin, output res, h, n, z, v, c);
endinterface : alu_if

// >>> rtl/alu_flag_unit.sv
// Combinational arithmetic and condition-code unit for byte and word work.
// Assumes operands are stable for the cycle in which the core samples it.
`timescale 1ns/1ps
module alu_flag_unit
  import cpu_state_pkg::*;
(
  alu_if.unit bus
);
  logic [15:0] am;
  logic [15:0] bm;
  logic [16:0] full;
  logic [4:0]  half;
  logic        am_s;
  logic        bm_s;
  logic        r_s;
  logic        is_sub;

  always_comb begin
    am     = bus.word ? bus.a : {8'h00, bus.a[7:0]};
    bm     = bus.word ? bus.t : {8'h00, bus.t[7:0]};
    is_sub = 1'b0;
    if (bus.op == OP_INC || bus.op == OP_DEC) begin
      bm = 16'h0001;
    end
    full = 17'h00000;
    half = 5'h00;
    bus.res = 16'h0000;
    bus.c   = 1'b0;
    bus.v   = 1'b0;
    bus.h   = 1'b0;
    case (bus.op)
      OP_ADD, OP_ADDC, OP_INC: begin
        full = {1'b0, am} + {1'b0, bm} + {16'h0000, bus.op == OP_ADDC && bus.cin};
        half = {1'b0, am[3:0]} + {1'b0, bm[3:0]} + {4'h0, bus.op == OP_ADDC && bus.cin};
      end
      OP_SUB, OP_SUBC, OP_CMP, OP_DEC: begin
        is_sub = 1'b1;
        full = {1'b0, am} - {1'b0, bm} - {16'h0000, bus.op == OP_SUBC && bus.cin};
        half = {1'b0, am[3:0]} - {1'b0, bm[3:0]} - {4'h0, bus.op == OP_SUBC && bus.cin};
      end
      OP_AND: full = {1'b0, am & bm};
      OP_OR:  full = {1'b0, am | bm};
      OP_XOR: full = {1'b0, am ^ bm};
      OP_SHL: full = {1'b0, am[14:0], bus.cin};
      OP_SHR: full = {1'b0, bus.word ? bus.cin : 1'b0, am[15:9],
                      bus.word ? am[8] : bus.cin, am[7:1]};
      default: full = 17'h00000;
    endcase
    bus.res = bus.word ? full[15:0] : {8'h00, full[7:0]};
    am_s = bus.word ? am[15] : am[7];
    bm_s = bus.word ? bm[15] : bm[7];
    r_s  = bus.word ? bus.res[15] : bus.res[7];
    case (bus.op)
      OP_ADD, OP_ADDC, OP_INC, OP_SUB, OP_SUBC, OP_CMP, OP_DEC: begin
        bus.h = half[4];
        bus.c = bus.word ? full[16] : full[8];
        bus.v = (is_sub ? (am_s != bm_s) : (am_s == bm_s)) && (r_s != am_s);
      end
      OP_SHL: bus.c = am_s;
      OP_SHR: bus.c = am[0];
      default: bus.c = 1'b0;
    endcase
    bus.n = r_s;
    bus.z = (bus.res == 16'h0000);
  end
endmodule : alu_flag_unit

// >>> rtl/cpu_state_core.sv
// Programmer-visible CPU state: dedicated registers, status word, flags,
// interrupt mask check, bank addressing and address-space region probe.
// Assumes a single-cycle register port master that never waits.
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module cpu_state_core
  import cpu_state_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [15:0] rdata_o,
  input  wire logic        fetch_i,
  input  wire logic        irq_req_i,
  input  wire logic [1:0]  irq_level_i,
  output logic             irq_accept_o,
  output logic      [15:0] pc_o,
  output logic      [15:0] psw_o,
  output logic      [15:0] gpr_addr_o
);
  alu_if alu ();

  logic [15:0] pc;
  logic [15:0] acc;
  logic [15:0] tmp;
  logic [15:0] idx;
  logic [15:0] ext;
  logic [15:0] stk;
  logic [7:0]  bank_ptr;
  logic [7:0]  cond;
  logic [2:0]  gpr_sel;
  logic [15:0] probe_addr;
  region_t     region;
  logic [4:0]  last_cmd;
  logic [1:0]  last_taken_level;
  logic        irq_accept;
  logic [15:0] gpr_addr;

  logic        wr_pc;
  logic        wr_acc;
  logic        wr_tmp;
  logic        wr_idx;
  logic        wr_ext;
  logic        wr_stk;
  logic        wr_psw;
  logic        wr_cmd;
  logic        wr_sel;
  logic        wr_probe;
  logic        cmd_writes_acc;
  logic [1:0]  mask_level;
  logic [1:0]  req_level;
  logic        would_accept;
  logic [15:0] next_acc;
  logic [7:0]  next_cond;
  logic [15:0] next_gpr_addr;
  logic [15:0] next_rdata;
  region_t     next_region;

  alu_flag_unit u_flags (
    .bus (alu.unit)
  );

  // Write strobes, one per register
  always_comb begin
    wr_pc    = wr_i && (addr_i == OFS_PC);
    wr_acc   = wr_i && (addr_i == OFS_ACC);
    wr_tmp   = wr_i && (addr_i == OFS_TMP);
    wr_idx   = wr_i && (addr_i == OFS_IDX);
    wr_ext   = wr_i && (addr_i == OFS_EXT);
    wr_stk   = wr_i && (addr_i == OFS_STK);
    wr_psw   = wr_i && (addr_i == OFS_PSW);
    wr_cmd   = wr_i && (addr_i == OFS_CMD);
    wr_sel   = wr_i && (addr_i == OFS_GPR_SEL);
    wr_probe = wr_i && (addr_i == OFS_PROBE);
  end

  // Operands always come from the live accumulators
  always_comb begin
    alu.a    = acc;
    alu.t    = tmp;
    alu.op   = alu_op_t'(wdata_i[3:0]);
    alu.word = wdata_i[CMD_WORD_BIT];
    alu.cin  = cond[COND_C];
  end

  // Compare only sets flags; op codes above the table are ignored
  always_comb begin
    cmd_writes_acc = 1'b0;
    if (wr_cmd && wdata_i[3:0] <= 4'(OP_SHR)) begin
      cmd_writes_acc = (alu.op != OP_CMP);
    end
  end

  // Byte results leave the accumulator's upper byte untouched
  always_comb begin
    next_acc = acc;
    if (wr_acc) begin
      next_acc = wdata_i;
    end else if (cmd_writes_acc) begin
      next_acc = alu.word ? alu.res : {acc[15:8], alu.res[7:0]};
    end
  end

  // Flag update keeps the interrupt bits, replaces the result flags
  always_comb begin
    next_cond = cond;
    if (wr_psw) begin
      next_cond = wdata_i[7:0];
    end else if (wr_cmd && wdata_i[3:0] <= 4'(OP_SHR)) begin
      next_cond[COND_H] = alu.h;
      next_cond[COND_N] = alu.n;
      next_cond[COND_Z] = alu.z;
      next_cond[COND_V] = alu.v;
      next_cond[COND_C] = alu.c;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pc <= PC_RST;
    end else if (wr_pc) begin
      pc <= wdata_i;
    end else if (fetch_i) begin
      pc <= pc + 16'h0001;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      acc <= WORD_RST;
    end else begin
      acc <= next_acc;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tmp <= WORD_RST;
    end else if (wr_tmp) begin
      tmp <= wdata_i;
    end
  end

  // Pointer registers are plain 16-bit storage
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      idx <= WORD_RST;
      ext <= WORD_RST;
      stk <= WORD_RST;
    end else begin
      if (wr_idx) begin
        idx <= wdata_i;
      end
      if (wr_ext) begin
        ext <= wdata_i;
      end
      if (wr_stk) begin
        stk <= wdata_i;
      end
    end
  end

  // Status word: bank pointer high, condition codes low
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bank_ptr <= BANK_PTR_RST;
      cond     <= COND_RST;
    end else begin
      if (wr_psw) begin
        bank_ptr <= wdata_i[15:8];
      end
      cond <= next_cond;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      last_cmd <= 5'h00;
    end else if (wr_cmd) begin
      last_cmd <= wdata_i[4:0];
    end
  end

  // Register number within the current bank
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      gpr_sel <= 3'h0;
    end else if (wr_sel) begin
      gpr_sel <= wdata_i[2:0];
    end
  end

  // Only the low nibble of the pointer picks a bank, so at most 16 exist
  always_comb begin
    next_gpr_addr = BANK_BASE + {9'h000, bank_ptr[3:0] & BANK_LAST, gpr_sel};
  end

  // Address follows pointer or selector one cycle later
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      gpr_addr <= BANK_BASE;
    end else begin
      gpr_addr <= next_gpr_addr;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      probe_addr <= 16'h0000;
    end else if (wr_probe) begin
      probe_addr <= wdata_i;
    end
  end

  // Region map: I/O lowest, data above it, program and vectors on top
  always_comb begin
    if (probe_addr <= IO_LAST) begin
      next_region = REGION_IO;
    end else if (probe_addr < PROG_FIRST) begin
      next_region = REGION_DATA;
    end else if (probe_addr < VECT_FIRST) begin
      next_region = REGION_PROG;
    end else begin
      next_region = REGION_VECT;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      region <= REGION_IO;
    end else begin
      region <= next_region;
    end
  end

  // Lower level number means higher priority
  always_comb begin
    mask_level   = level_decode({cond[COND_MASK_HI], cond[COND_MASK_LO]});
    req_level    = level_decode(irq_level_i);
    would_accept = 1'b0;
    if (cond[COND_I] && mask_level != LVL_BLOCK_ALL) begin
      would_accept = irq_req_i && (req_level < mask_level);
    end
  end

  // Acceptance is a one-cycle pulse per cycle of qualifying request
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_accept       <= 1'b0;
      last_taken_level <= 2'h0;
    end else begin
      irq_accept <= would_accept;
      if (would_accept) begin
        last_taken_level <= req_level;
      end
    end
  end

  // Read mux; data stands only in the cycle after the strobe
  always_comb begin
    next_rdata = 16'h0000;
    if (rd_i) begin
      case (addr_i)
        OFS_PC:       next_rdata = pc;
        OFS_ACC:      next_rdata = acc;
        OFS_TMP:      next_rdata = tmp;
        OFS_IDX:      next_rdata = idx;
        OFS_EXT:      next_rdata = ext;
        OFS_STK:      next_rdata = stk;
        OFS_PSW:      next_rdata = {bank_ptr, cond};
        OFS_CMD:      next_rdata = {11'h000, last_cmd};
        OFS_GPR_SEL:  next_rdata = {13'h0000, gpr_sel};
        OFS_GPR_ADDR: next_rdata = gpr_addr;
        OFS_PROBE:    next_rdata = {12'h000, 2'(region), 2'h0};
        OFS_IRQ_STAT: next_rdata = {10'h000, last_taken_level, mask_level,
                                    would_accept, cond[COND_I]};
        default:      next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 16'h0000;
    end else begin
      rdata_o <= next_rdata;
    end
  end

  // Mirrors so that every output leaves a flip-flop
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pc_o         <= PC_RST;
      psw_o        <= {BANK_PTR_RST, COND_RST};
      gpr_addr_o   <= BANK_BASE;
      irq_accept_o <= 1'b0;
    end else begin
      pc_o         <= pc;
      psw_o        <= {bank_ptr, cond};
      gpr_addr_o   <= gpr_addr;
      irq_accept_o <= irq_accept;
    end
  end
endmodule : cpu_state_core

// >>> bench/cpu_state_asserts.sv
// Port-level assertions for cpu_state_core.
// Assumes a bind from the bench top; one clock, async active-high reset.
`timescale 1ns/1ps
module cpu_state_asserts
  import cpu_state_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic [7:0]  addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [15:0] rdata_o,
  input wire logic        fetch_i,
  input wire logic        irq_req_i,
  input wire logic [1:0]  irq_level_i,
  input wire logic        irq_accept_o,
  input wire logic [15:0] pc_o,
  input wire logic [15:0] psw_o,
  input wire logic [15:0] gpr_addr_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  function automatic logic [1:0] lv(input logic [1:0] c);
    lv = (c == 2'h0) ? 2'h1 : c;
  endfunction : lv
  sequence s_psw_wr;
    wr_i && addr_i == OFS_PSW;
  endsequence
  sequence s_pc_wr;
    wr_i && addr_i == OFS_PC;
  endsequence
  property p_psw_load;
    s_psw_wr |=> ##1 psw_o == $past(wdata_i, 2);
  endproperty
  a_psw_load: assert property (p_psw_load) else $error("status word load");
  property p_psw_read;
    rd_i && addr_i == OFS_PSW |=> rdata_o == psw_o;
  endproperty
  a_psw_read: assert property (p_psw_read) else $error("status word read");
  property p_pc_load;
    s_pc_wr |=> ##1 pc_o == $past(wdata_i, 2);
  endproperty
  a_pc_load: assert property (p_pc_load) else $error("pc load");
  // A bus write to PC on the same edge overrides the increment
  property p_pc_fetch;
    fetch_i && !(wr_i && addr_i == OFS_PC) |=> ##1 pc_o == $past(pc_o) + 16'h0001;
  endproperty
  a_pc_fetch: assert property (p_pc_fetch) else $error("pc increment");
  property p_pc_read;
    rd_i && addr_i == OFS_PC |=> rdata_o == pc_o;
  endproperty
  a_pc_read: assert property (p_pc_read) else $error("pc read");
  property p_irq;
    irq_accept_o == ($past(irq_req_i, 2) && $past(psw_o[COND_I]) &&
      $past(psw_o[5:4]) != LVL_BLOCK_ALL && lv($past(irq_level_i, 2)) < lv($past(psw_o[5:4])));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt acceptance");
  property p_irq_stat;
    rd_i && addr_i == OFS_IRQ_STAT |=> rdata_o[0] == psw_o[COND_I];
  endproperty
  a_irq_stat: assert property (p_irq_stat) else $error("enable flag status");
  property p_gpr_range;
    gpr_addr_o[15:7] == 9'h002;
  endproperty
  a_gpr_range: assert property (p_gpr_range) else $error("bank address range");
endmodule : cpu_state_asserts

// >>> bench/test_cpu_flags_and_register_banks.sv
// Self-checking bench: register port tasks, flag model, interrupt mask, banks.
// Assumes the package, design and checker are compiled before this file.
`timescale 1ns/1ps
module test_cpu_flags_and_register_banks;
  import cpu_state_pkg::*;
  logic        clk_i, rst_i, wr_i, rd_i, fetch_i, irq_req_i, irq_accept_o, w, x;
  logic [7:0]  addr_i;
  logic [15:0] wdata_i, rdata_o, pc_o, psw_o, gpr_addr_o, a, t, p, q, e, k;
  logic [1:0]  irq_level_i;
  logic [20:0] m;
  logic [31:0] r0;
  int          fails, checked, op;
  logic [15:0] bnd [8] = '{16'h0000, 16'h007F, 16'h0080, 16'h7FFF,
                           16'h8000, 16'hFFBF, 16'hFFC0, 16'hFFFF};
  cpu_state_core dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .fetch_i(fetch_i), .irq_req_i(irq_req_i),
    .irq_level_i(irq_level_i), .irq_accept_o(irq_accept_o), .pc_o(pc_o), .psw_o(psw_o),
    .gpr_addr_o(gpr_addr_o));
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  task automatic report_and_stop();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] ad, input logic [15:0] d);
    @(posedge clk_i);
    addr_i  <= ad;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] ad, output logic [15:0] d);
    @(posedge clk_i);
    addr_i <= ad;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask : rd
  function automatic logic [1:0] lv(input logic [1:0] c);
    lv = (c == 2'h0) ? 2'h1 : c;
  endfunction : lv
  // Returns {H, N, Z, V, C, result}; byte work uses only the low byte
  function automatic logic [20:0] alu(input int o, input logic [15:0] xa, xb,
                                      input logic wd, ci);
    logic [15:0] mk, aa, bb;
    logic [16:0] r;
    logic [4:0]  l;
    logic        s, kc, h, v, c;
    int          n;
    n  = wd ? 15 : 7;
    mk = wd ? 16'hFFFF : 16'h00FF;
    aa = xa & mk;
    bb = (o == 5 || o == 6) ? 16'h0001 : xb & mk;
    s  = (o inside {2, 3, 4, 6});
    kc = (o == 1 || o == 3) ? ci : 1'b0;
    r  = s ? {1'b0, aa} - bb - kc : {1'b0, aa} + bb + kc;
    l  = s ? aa[3:0] - bb[3:0] - kc : aa[3:0] + bb[3:0] + kc;
    h  = l[4];
    c  = r[n + 1];
    v  = (aa[n] ^ r[n]) & (s ^ ~(aa[n] ^ bb[n]));
    if (o >= 7) begin
      h = 1'b0;
      v = 1'b0;
      c = 1'b0;
      r = (o == 7) ? {1'b0, aa & bb} : (o == 8) ? {1'b0, aa | bb} : {1'b0, aa ^ bb};
    end
    if (o == 10) begin
      c = aa[n];
      r = {aa, ci} & {1'b0, mk};
    end
    if (o == 11) begin
      c = aa[0];
      r = {1'b0, aa >> 1} | ({16'h0000, ci} << n);
    end
    alu = {h, r[n], (r[15:0] & mk) == 16'h0000, v, c, r[15:0] & mk};
  endfunction : alu
  initial begin
    repeat (50000) @(posedge clk_i);
    fails++;
    report_and_stop();
  end
  initial begin
    rst_i       = 1'b1;
    wr_i        = 1'b0;
    rd_i        = 1'b0;
    fetch_i     = 1'b0;
    irq_req_i   = 1'b0;
    irq_level_i = 2'h0;
    addr_i      = 8'h00;
    wdata_i     = 16'h0000;
    r0          = $urandom(21);
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int j = 0; j < 2; j++) begin
      #1 chk(psw_o & 16'h0040, 16'h0000);
      chk(gpr_addr_o, BANK_BASE);
      rd(OFS_PSW, q);
      chk(q, {BANK_PTR_RST, COND_RST});
      if (j == 0) begin
        for (int i = 0; i < 60; i++) begin
          op = i % 12;
          r0 = $urandom;
          a  = r0[15:0];
          t  = r0[31:16];
          r0 = $urandom;
          p  = r0[15:0];
          w  = r0[16];
          wr(OFS_PSW, p);
          wr(OFS_ACC, a);
          wr(OFS_TMP, t);
          wr(OFS_CMD, {11'h000, w, op[3:0]});
          m = alu(op, a, t, w, p[COND_C]);
          e = (op == 4) ? a : w ? m[15:0] : {a[15:8], m[7:0]};
          rd(OFS_ACC, q);
          chk(q, e);
          // Carry, half carry and overflow of INC and DEC are left unchecked
          k = (op == 5 || op == 6) ? 16'hFF7C : 16'hFFFF;
          rd(OFS_PSW, q);
          chk(q & k, {p[15:8], m[20], p[6:4], m[19:16]} & k);
        end
        for (int i = 0; i < 32; i++) begin
          wr(OFS_PSW, {9'h000, i[0], i[2:1], 4'h0});
          rd(OFS_IRQ_STAT, q);
          chk(q & 16'h0001, {15'h0000, i[0]});
          @(posedge clk_i);
          irq_req_i   <= 1'b1;
          irq_level_i <= i[4:3];
          @(posedge clk_i);
          irq_req_i <= 1'b0;
          @(posedge clk_i);
          x = i[0] && i[2:1] != 2'h3 && lv(i[4:3]) < lv(i[2:1]);
          #1 chk({15'h0000, irq_accept_o}, {15'h0000, x});
        end
        for (int i = 0; i < 6; i++) begin
          r0 = (i == 0) ? 32'h0000_0F07 : $urandom;
          wr(OFS_PSW, {r0[15:8], 8'h30});
          wr(OFS_GPR_SEL, {13'h0000, r0[2:0]});
          repeat (3) @(posedge clk_i);
          e = BANK_BASE + {9'h000, r0[11:8], 3'h0} + {13'h0000, r0[2:0]};
          #1 chk(gpr_addr_o, e);
          rd(OFS_GPR_ADDR, q);
          chk(q, e);
        end
        for (int i = 0; i < 8; i++) begin
          wr(OFS_PROBE, bnd[i]);
          rd(OFS_PROBE, q);
          chk(q & 16'h000C, {12'h000, i[2:1], 2'h0});
        end
        for (int i = 3; i < 8'h0E; i++) begin
          r0 = $urandom;
          if (i < 6) wr(i[7:0], r0[15:0]);
          rd(i[7:0], q);
          if (i < 6 || i > 11) chk(q, (i < 6) ? r0[15:0] : 16'h0000);
        end
        wr(OFS_PC, 16'hFFFE);
        fetch_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        // Fetch is still high on the write edge, so the write must win
        @(posedge clk_i);
        addr_i  <= OFS_PC;
        wdata_i <= 16'h1234;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i    <= 1'b0;
        fetch_i <= 1'b0;
        rd(OFS_PC, q);
        chk(q, 16'h1234);
        wr(OFS_PC, 16'hFFFE);
        @(posedge clk_i);
        fetch_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        fetch_i <= 1'b0;
        rd(OFS_PC, q);
        chk(q, 16'h0001);
        @(posedge clk_i);
        rst_i <= 1'b1;
        @(posedge clk_i);
        rst_i <= 1'b0;
      end
    end
    report_and_stop();
  end
endmodule : test_cpu_flags_and_register_banks
bind cpu_state_core cpu_state_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .fetch_i(fetch_i),
  .irq_req_i(irq_req_i), .irq_level_i(irq_level_i), .irq_accept_o(irq_accept_o),
  .pc_o(pc_o), .psw_o(psw_o), .gpr_addr_o(gpr_addr_o));
